// ---- hw/gfc_defs.svh ----
`ifndef GFC_DEFS_SVH
`define GFC_DEFS_SVH

// ----------------------------------------
// Register offsets and fields
// ----------------------------------------
`define GFC_OFF_CTRL 8'h00
`define GFC_OFF_DISP 8'h04
`define GFC_OFF_CMD 8'h08
`define GFC_OFF_STATUS 8'h0c
`define GFC_OFF_READING 8'h10
`define GFC_CTRL_MODE_LSB 0
`define GFC_CTRL_EXT_BIT 3
`define GFC_CTRL_INF_BIT 4
`define GFC_CTRL_RST 8'h03
`define GFC_DISP_RST 7'h0a
`define GFC_DISP_MIN 7'h01
`define GFC_DISP_MAX 7'h64
`define GFC_CMD_RESET_BIT 0

// ----------------------------------------
// Timing
// ----------------------------------------
`define GFC_CLK_NS 4
`define GFC_REF_NS 1000
`define GFC_REF_DIV (`GFC_REF_NS / `GFC_CLK_NS)
`define GFC_STORE_NS 7000
`define GFC_STORE_CYC (`GFC_STORE_NS / `GFC_CLK_NS)
`define GFC_RST_NS 28000
`define GFC_RST_CYC (`GFC_RST_NS / `GFC_CLK_NS)
`define GFC_DISP_UNIT_NS 100000000
`define GFC_DISP_UNIT_CYC (`GFC_DISP_UNIT_NS / `GFC_CLK_NS)
`define GFC_TB_FIRST_DIV 1000

`endif

// ---- hw/gfc_pkg.sv ----
package gfc_pkg;
  typedef enum logic [2:0] {
    GFC_MODE_1MS = 3'h0,
    GFC_MODE_10MS = 3'h1,
    GFC_MODE_100MS = 3'h2,
    GFC_MODE_1S = 3'h3,
    GFC_MODE_10S = 3'h4,
    GFC_MODE_100S = 3'h5,
    GFC_MODE_CNT_A = 3'h6,
    GFC_MODE_CNT_OFF = 3'h7
  } gfc_mode_t;
  typedef logic [3:0] gfc_bcd_t;
endpackage : gfc_pkg

// ---- hw/gfc_decade.sv ----
`timescale 1ns/10ps
`default_nettype none
module gfc_decade #(
  parameter bit QUIBIN = 1'b0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Count control
  input wire logic clr_i,
  input wire logic inc_i,
  // Count outputs
  output gfc_pkg::gfc_bcd_t bcd_o,
  output logic carry_o
);

  // ----------------------------------------
  // Counter styles
  // ----------------------------------------
  generate
    if (QUIBIN) begin : g_quibin
      logic [4:0] ring_q;
      logic bin_q;
      logic [3:0] quin;
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          ring_q <= 5'h01;
          bin_q <= 1'b0;
        end else if (clr_i) begin
          ring_q <= 5'h01;
          bin_q <= 1'b0;
        end else if (inc_i) begin
          ring_q <= {ring_q[3:0], ring_q[4]};
          if (ring_q[4]) begin
            bin_q <= ~bin_q;
          end
        end
      end
      // A ring that somehow holds no bit reads as zero rather than garbage.
      assign quin = ring_q[4] ? 4'h4 : ring_q[3] ? 4'h3 : ring_q[2] ? 4'h2 : ring_q[1] ? 4'h1 : 4'h0;
      assign bcd_o = quin + (bin_q ? 4'h5 : 4'h0);
      assign carry_o = inc_i & ring_q[4] & bin_q;
    end else begin : g_binary
      logic [3:0] cnt_q;
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          cnt_q <= 4'h0;
        end else if (clr_i) begin
          cnt_q <= 4'h0;
        end else if (inc_i) begin
          cnt_q <= (cnt_q == 4'h9) ? 4'h0 : cnt_q + 4'h1;
        end
      end
      assign bcd_o = cnt_q;
      assign carry_o = inc_i & (cnt_q == 4'h9);
    end
  endgenerate

endmodule : gfc_decade
`default_nettype wire

// ---- hw/gfc_top.sv ----
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "gfc_defs.svh"
module gfc_top #(
  parameter int RST_CYC = `GFC_RST_CYC,
  parameter int DISP_UNIT_CYC = `GFC_DISP_UNIT_CYC
) (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic SYS_RST_I,
  // AXI4-Lite write address
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  // AXI4-Lite write data
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  // AXI4-Lite write response
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  // AXI4-Lite read address
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  // AXI4-Lite read data
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  // Measured input and external reference pins
  input wire logic INPUT_A_I,
  input wire logic REF_B_I,
  // Readout
  output logic [59:0] DIGIT_SEL_O,
  output logic [5:0] DEC_POINT_O,
  output logic [2:0] PRINT_DP_O,
  output logic GATE_LAMP_O,
  output logic STORE_O,
  output logic RESET_PULSE_O
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr[7:2] == off[7:2]);
  endfunction : hit

  function automatic logic [9:0] onehot10(input gfc_pkg::gfc_bcd_t v);
    onehot10 = (v > 4'h9) ? 10'h000 : 10'h001 << v;
  endfunction : onehot10

  // ----------------------------------------
  // Register file state
  // ----------------------------------------
  logic [7:0] ctrl_q;
  logic [6:0] disp_int_q;
  logic aw_full_q;
  logic w_full_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;

  wire do_wr = aw_full_q & w_full_q & ~bvalid_q;
  wire wr_ctrl = do_wr & hit(awaddr_q, `GFC_OFF_CTRL) & wstrb_q[0];
  wire wr_disp = do_wr & hit(awaddr_q, `GFC_OFF_DISP) & wstrb_q[0];
  wire wr_cmd = do_wr & hit(awaddr_q, `GFC_OFF_CMD) & wstrb_q[0];
  wire wr_mapped = hit(awaddr_q, `GFC_OFF_CTRL) | hit(awaddr_q, `GFC_OFF_DISP) | hit(awaddr_q, `GFC_OFF_CMD)
                 | hit(awaddr_q, `GFC_OFF_STATUS) | hit(awaddr_q, `GFC_OFF_READING);
  wire ar_hs = S_AXI_ARVALID_I & ~rvalid_q;

  gfc_pkg::gfc_mode_t mode;
  assign mode = gfc_pkg::gfc_mode_t'(ctrl_q[`GFC_CTRL_MODE_LSB +: 3]);
  wire ext_ref = ctrl_q[`GFC_CTRL_EXT_BIT];
  wire infinite = ctrl_q[`GFC_CTRL_INF_BIT];
  wire count_mode = (mode == gfc_pkg::GFC_MODE_CNT_A) | (mode == gfc_pkg::GFC_MODE_CNT_OFF);
  wire man_reset = wr_cmd & wdata_q[`GFC_CMD_RESET_BIT];

  assign S_AXI_AWREADY_O = ~aw_full_q & ~bvalid_q;
  assign S_AXI_WREADY_O = ~w_full_q & ~bvalid_q;
  assign S_AXI_BVALID_O = bvalid_q;
  assign S_AXI_BRESP_O = bresp_q;
  assign S_AXI_ARREADY_O = ~rvalid_q;
  assign S_AXI_RVALID_O = rvalid_q;
  assign S_AXI_RRESP_O = rresp_q;
  assign S_AXI_RDATA_O = rdata_q;

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  // Address and data are caught independently, so either may arrive first.
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
    end else begin
      if (S_AXI_AWVALID_I & S_AXI_AWREADY_O) begin
        aw_full_q <= 1'b1;
        awaddr_q <= S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I & S_AXI_WREADY_O) begin
        w_full_q <= 1'b1;
        wdata_q <= S_AXI_WDATA_I;
        wstrb_q <= S_AXI_WSTRB_I;
      end
      if (do_wr) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_mapped ? 2'h0 : 2'h2;
      end else if (bvalid_q & S_AXI_BREADY_I) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Out-of-range display intervals are clamped, so the timer never runs zero or forever.
  wire [6:0] disp_wval = wdata_q[6:0];
  wire [6:0] disp_clamp = (disp_wval < `GFC_DISP_MIN) ? `GFC_DISP_MIN :
                          (disp_wval > `GFC_DISP_MAX) ? `GFC_DISP_MAX : disp_wval;

  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ctrl_q <= `GFC_CTRL_RST;
      disp_int_q <= `GFC_DISP_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= {3'h0, wdata_q[4:0]};
      end
      if (wr_disp) begin
        disp_int_q <= disp_clamp;
      end
    end
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0] a_sync_q;
  logic [1:0] b_sync_q;
  logic a_prev_q;
  logic b_prev_q;
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      a_sync_q <= 2'h0;
      b_sync_q <= 2'h0;
      a_prev_q <= 1'b0;
      b_prev_q <= 1'b0;
    end else begin
      a_sync_q <= {a_sync_q[0], INPUT_A_I};
      b_sync_q <= {b_sync_q[0], REF_B_I};
      a_prev_q <= a_sync_q[1];
      b_prev_q <= b_sync_q[1];
    end
  end
  wire a_rise = a_sync_q[1] & ~a_prev_q;
  wire b_fall = ~b_sync_q[1] & b_prev_q;

  // ----------------------------------------
  // Reference and time base
  // ----------------------------------------
  logic [7:0] osc_q;
  logic [9:0] ms_q;
  wire osc_tick = (osc_q == 8'(`GFC_REF_DIV - 1));
  wire ref_tick = ext_ref ? b_fall : osc_tick;
  wire [5:0] tb_tick;

  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      osc_q <= 8'h00;
      ms_q <= 10'h000;
    end else begin
      osc_q <= osc_tick ? 8'h00 : osc_q + 8'h01;
      if (ref_tick) begin
        ms_q <= (ms_q == 10'(`GFC_TB_FIRST_DIV - 1)) ? 10'h000 : ms_q + 10'h001;
      end
    end
  end
  assign tb_tick[0] = ref_tick & (ms_q == 10'(`GFC_TB_FIRST_DIV - 1));

  // The time base runs free and is never touched by the measurement reset.
  genvar k;
  generate
    for (k = 1; k < 6; k++) begin : g_tb
      logic [3:0] dec_q;
      always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
          dec_q <= 4'h0;
        end else if (tb_tick[k-1]) begin
          dec_q <= (dec_q == 4'h9) ? 4'h0 : dec_q + 4'h1;
        end
      end
      assign tb_tick[k] = tb_tick[k-1] & (dec_q == 4'h9);
    end
  endgenerate

  wire sel_tick = ~count_mode & tb_tick[mode];

  // ----------------------------------------
  // Gate and display control
  // ----------------------------------------
  logic gate_q;
  logic disp_q;
  logic [10:0] store_cnt_q;
  logic [31:0] rst_cnt_q;
  logic [31:0] unit_q;
  logic [6:0] tenth_q;

  wire rst_busy = (rst_cnt_q != 32'h0);
  wire gate_toggle = sel_tick & ~disp_q & ~rst_busy;
  wire gate_fall = gate_toggle & gate_q;
  wire timer_run = disp_q & ~infinite & ~rst_busy;
  wire unit_tick = timer_run & (unit_q == 32'(DISP_UNIT_CYC - 1));
  wire timer_done = unit_tick & (tenth_q == disp_int_q - 7'h01);
  wire rst_trig = ~rst_busy & (timer_done | man_reset);
  wire store_act = (store_cnt_q != 11'h000) | count_mode;

  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      gate_q <= 1'b0;
      disp_q <= 1'b0;
    end else begin
      if (count_mode) begin
        gate_q <= (mode == gfc_pkg::GFC_MODE_CNT_A);
        disp_q <= 1'b0;
      end else begin
        if (rst_busy) begin
          gate_q <= 1'b0;
          disp_q <= 1'b0;
        end else if (gate_toggle) begin
          gate_q <= ~gate_q;
          disp_q <= gate_q;
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      store_cnt_q <= 11'h000;
    end else if (gate_fall) begin
      store_cnt_q <= 11'(`GFC_STORE_CYC);
    end else if (store_cnt_q != 11'h000) begin
      store_cnt_q <= store_cnt_q - 11'h001;
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      unit_q <= 32'h0;
      tenth_q <= 7'h00;
    end else if (~timer_run) begin
      unit_q <= 32'h0;
      tenth_q <= 7'h00;
    end else if (unit_tick) begin
      unit_q <= 32'h0;
      tenth_q <= tenth_q + 7'h01;
    end else begin
      unit_q <= unit_q + 32'h1;
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      rst_cnt_q <= 32'h0;
    end else if (rst_trig) begin
      rst_cnt_q <= 32'(RST_CYC);
    end else if (rst_busy) begin
      rst_cnt_q <= rst_cnt_q - 32'h1;
    end
  end

  // ----------------------------------------
  // Count chain
  // ----------------------------------------
  wire [6:0] carry;
  wire [23:0] chain_bcd;
  assign carry[0] = gate_q & a_rise;

  // The top carry goes nowhere, so the reading simply wraps.
  generate
    for (k = 0; k < 6; k++) begin : g_chain
      gfc_decade #(
        .QUIBIN(k == 0)
      ) u_dec (
        .clk_i(CORE_CLK_I),
        .rst_i(SYS_RST_I),
        .clr_i(rst_busy),
        .inc_i(carry[k]),
        .bcd_o(chain_bcd[4*k +: 4]),
        .carry_o(carry[k+1])
      );
    end
  endgenerate

  // ----------------------------------------
  // Storage and readout
  // ----------------------------------------
  logic [23:0] reading_q;
  logic [59:0] digit_q;
  logic [5:0] dp_q;
  logic [2:0] pdp_q;

  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      reading_q <= 24'h000000;
    end else if (store_act) begin
      reading_q <= chain_bcd;
    end
  end

  // Decoding is registered so the readout never shows decoder glitches.
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      digit_q <= 60'h0;
      dp_q <= 6'h00;
      pdp_q <= 3'h0;
    end else begin
      for (int i = 0; i < 6; i++) begin
        digit_q[10*i +: 10] <= onehot10(reading_q[4*i +: 4]);
      end
      dp_q <= count_mode ? 6'h00 : 6'(6'h01 << mode);
      pdp_q <= count_mode ? 3'h0 : mode;
    end
  end

  assign DIGIT_SEL_O = digit_q;
  assign DEC_POINT_O = dp_q;
  assign PRINT_DP_O = pdp_q;
  assign GATE_LAMP_O = gate_q;
  assign STORE_O = store_act;
  assign RESET_PULSE_O = rst_busy;

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  wire [31:0] status_w = {28'h0, rst_busy, store_act, disp_q, gate_q};
  wire [31:0] rd_mux = hit(S_AXI_ARADDR_I, `GFC_OFF_CTRL) ? {24'h0, ctrl_q} :
                       hit(S_AXI_ARADDR_I, `GFC_OFF_DISP) ? {25'h0, disp_int_q} :
                       hit(S_AXI_ARADDR_I, `GFC_OFF_STATUS) ? status_w :
                       hit(S_AXI_ARADDR_I, `GFC_OFF_READING) ? {8'h0, reading_q} : 32'h0;
  wire rd_mapped = hit(S_AXI_ARADDR_I, `GFC_OFF_CTRL) | hit(S_AXI_ARADDR_I, `GFC_OFF_DISP)
                 | hit(S_AXI_ARADDR_I, `GFC_OFF_CMD) | hit(S_AXI_ARADDR_I, `GFC_OFF_STATUS)
                 | hit(S_AXI_ARADDR_I, `GFC_OFF_READING);

  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      rvalid_q <= 1'b0;
      rresp_q <= 2'h0;
      rdata_q <= 32'h0;
    end else if (ar_hs) begin
      rvalid_q <= 1'b1;
      rresp_q <= rd_mapped ? 2'h0 : 2'h2;
      rdata_q <= rd_mux;
    end else if (rvalid_q & S_AXI_RREADY_I) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule : gfc_top
`default_nettype wire

// ---- tb/gfc_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
module gfc_monitor #(
  parameter int RST_CYC = 7000,
  parameter int DISP_UNIT_CYC = 25000000
) (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic SYS_RST_I,
  // Readout
  input wire logic [59:0] DIGIT_SEL_O,
  input wire logic [5:0] DEC_POINT_O,
  input wire logic [2:0] PRINT_DP_O,
  input wire logic GATE_LAMP_O,
  input wire logic STORE_O,
  input wire logic RESET_PULSE_O
);
  // ----------------------------------------
  // Pulse length counters
  // ----------------------------------------
  localparam int STORE_CYC = 1750;
  logic [31:0] st_cnt_q;
  logic [31:0] rp_cnt_q;
  // Count modes show no decimal point, so this tells frequency modes apart.
  wire logic freq_mode = |DEC_POINT_O;
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      st_cnt_q <= 32'h0;
      rp_cnt_q <= 32'h0;
    end else begin
      st_cnt_q <= STORE_O ? st_cnt_q + 32'h1 : 32'h0;
      rp_cnt_q <= RESET_PULSE_O ? rp_cnt_q + 32'h1 : 32'h0;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (SYS_RST_I);
  close_store_a: assert property ($fell(GATE_LAMP_O) && freq_mode && !RESET_PULSE_O |=> STORE_O)
    else $error("store pulse missing after gate closure");
  store_len_a: assert property ($fell(STORE_O) && freq_mode |-> st_cnt_q == STORE_CYC)
    else $error("store pulse length wrong");
  reset_len_a: assert property ($fell(RESET_PULSE_O) |-> rp_cnt_q == RST_CYC)
    else $error("reset pulse length wrong");
  reset_shuts_gate_a: assert property (RESET_PULSE_O && $past(RESET_PULSE_O) && freq_mode |-> !GATE_LAMP_O)
    else $error("gate open during reset pulse");
  gate_open_clean_a: assert property ($rose(GATE_LAMP_O) && freq_mode |-> !STORE_O && !RESET_PULSE_O)
    else $error("gate opened during store or reset");
  digit_onehot_a: assert property ($onehot0(DIGIT_SEL_O[9:0]) && $onehot0(DIGIT_SEL_O[19:10])
    && $onehot0(DIGIT_SEL_O[29:20]) && $onehot0(DIGIT_SEL_O[39:30]) && $onehot0(DIGIT_SEL_O[49:40])
    && $onehot0(DIGIT_SEL_O[59:50]))
    else $error("digit select not one-hot");
  point_match_a: assert property (freq_mode |-> DEC_POINT_O == (6'h01 << PRINT_DP_O))
    else $error("decimal point and printer code disagree");
  point_count_a: assert property (!freq_mode |-> PRINT_DP_O == 3'h0)
    else $error("printer code set in count mode");
  count_store_a: assert property (GATE_LAMP_O && !freq_mode |-> STORE_O)
    else $error("store not held in count mode");
endmodule : gfc_monitor
bind gfc_top gfc_monitor #(.RST_CYC(RST_CYC), .DISP_UNIT_CYC(DISP_UNIT_CYC)) mon_u (
  .CORE_CLK_I(CORE_CLK_I), .SYS_RST_I(SYS_RST_I), .DIGIT_SEL_O(DIGIT_SEL_O), .DEC_POINT_O(DEC_POINT_O),
  .PRINT_DP_O(PRINT_DP_O), .GATE_LAMP_O(GATE_LAMP_O), .STORE_O(STORE_O), .RESET_PULSE_O(RESET_PULSE_O)
);
`default_nettype wire

// ---- tb/gfc_far_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module gfc_far_model (
  // Clock
  input wire logic clk_i,
  // Pins
  output logic ref_b_o = 1'b0,
  output logic sig_a_o = 1'b0
);
  // ----------------------------------------
  // External reference and measured signal
  // ----------------------------------------
  logic [1:0] div_q = 2'h0;
  // Free running reference, one tick each eight clocks, keeps gate times short.
  always @(posedge clk_i) begin
    div_q <= div_q + 2'h1;
    if (div_q == 2'h3) begin
      ref_b_o <= !ref_b_o;
    end
  end
  // Three clocks high and low so the synchroniser never misses an edge.
  task automatic send(input int n);
    repeat (n) begin
      sig_a_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      sig_a_o <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask : send
endmodule : gfc_far_model
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic clk, rst, awvalid, wvalid, arvalid, bready, rready;
  logic [3:0] wstrb;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdat;
  wire logic awready, wready, bvalid, arready, rvalid, lamp, store, rpulse, sig_a, ref_b;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [59:0] dsel;
  wire logic [5:0] dp;
  wire logic [2:0] pdp;
  int err_total = 0;
  int checks_done = 0;
  gfc_top #(.RST_CYC(8), .DISP_UNIT_CYC(2000)) dut_u (
    .CORE_CLK_I(clk), .SYS_RST_I(rst), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
    .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .INPUT_A_I(sig_a),
    .REF_B_I(ref_b), .DIGIT_SEL_O(dsel), .DEC_POINT_O(dp), .PRINT_DP_O(pdp), .GATE_LAMP_O(lamp),
    .STORE_O(store), .RESET_PULSE_O(rpulse)
  );
  gfc_far_model far_u (.clk_i(clk), .ref_b_o(ref_b), .sig_a_o(sig_a));
  initial begin
    clk = 1'b0;
    forever #2 clk = !clk;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (e !== s) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_t, w_t;
    aw_t = 1'b0;
    w_t = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_t && w_t)) begin
      @(posedge clk);
      if (awvalid && awready) begin
        aw_t = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_t = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!bvalid);
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    rdat = rdata;
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask : rd
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    rd(a, 2'h0);
    chk(n, e, rdat);
  endtask : rchk
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    rchk("ctrl", 8'h00, 32'h03);
    rchk("disp", 8'h04, 32'h0a);
    wr(8'h04, 32'h00, 2'h0);
    rchk("disp low", 8'h04, 32'h01);
    wr(8'h04, 32'hff, 2'h0);
    rchk("disp high", 8'h04, 32'h64);
    wr(8'h14, 32'h01, 2'h2);
    rd(8'h14, 2'h2);
    chk("unmapped", 32'h0, rdat);
    // A write whose low byte lane is off must leave the interval alone.
    wstrb <= 4'he;
    wr(8'h04, 32'h05, 2'h0);
    wstrb <= 4'hf;
    rchk("strobe", 8'h04, 32'h64);
    wr(8'h04, 32'h01, 2'h0);
  endtask : t_regs
  task automatic t_modes;
    for (int m = 0; m < 6; m++) begin
      wr(8'h00, 32'h08 | m, 2'h0);
      cyc(3);
      chk("point", 32'h1 << m, {26'h0, dp});
      chk("print", m, {29'h0, pdp});
    end
  endtask : t_modes
  // Display time exceeds the store pulse so the chain is cleared only after storage.
  task automatic t_meas;
    int n;
    wr(8'h00, 32'h08, 2'h0);
    @(posedge lamp);
    n = 0;
    fork
      far_u.send(1205);
      // The lamp is sampled between edges, where it has settled.
      begin
        @(negedge clk);
        while (lamp) begin
          n++;
          @(negedge clk);
        end
      end
    join
    chk("gate cycles", 8000, n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!rpulse);
    chk("display time", 1, {31'h0, n > 1999 && n < 2004});
    rchk("reading", 8'h10, 32'h1205);
    for (int i = 0; i < 6; i++) begin
      chk("digit", 32'h1 << ((32'h1205 >> 4 * i) & 32'hf), {22'h0, dsel[10 * i +: 10]});
    end
    @(posedge lamp);
    cyc(100);
    rchk("held", 8'h10, 32'h1205);
    @(negedge lamp);
    cyc(30);
    rchk("cleared", 8'h10, 32'h0);
  endtask : t_meas
  task automatic t_inf;
    int n;
    @(negedge rpulse);
    wr(8'h00, 32'h18, 2'h0);
    @(negedge lamp);
    n = 0;
    repeat (4000) begin
      @(posedge clk);
      if (rpulse || lamp) n++;
    end
    chk("auto reset", 0, n);
    rchk("status", 8'h0c, 32'h2);
    wr(8'h08, 32'h01, 2'h0);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!lamp && n < 9000);
    chk("reopen", 32'h1, {31'h0, lamp});
  endtask : t_inf
  task automatic t_cnt;
    wr(8'h00, 32'h0e, 2'h0);
    wr(8'h08, 32'h01, 2'h0);
    @(negedge rpulse);
    cyc(4);
    chk("count gate", 32'h3, {30'h0, lamp, store});
    far_u.send(7);
    cyc(8);
    rchk("count", 8'h10, 32'h7);
    wr(8'h00, 32'h0f, 2'h0);
    far_u.send(3);
    cyc(8);
    rchk("count off", 8'h10, 32'h7);
  endtask : t_cnt
  // ----------------------------------------
  // Sequence and verdict
  // ----------------------------------------
  task automatic conclude;
    if (err_total == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude
  initial begin
    rst = 1'b1;
    {awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
    {bready, rready, wstrb} = 6'h3f;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_modes();
    t_meas();
    t_inf();
    t_cnt();
    conclude();
  end
  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    conclude();
  end
endmodule : testbench
`default_nettype wire
